/* File: src/acp_regs.vh */
// Constants for the converter configuration port: map, fields, levels
`ifndef ACP_REGS_VH
`define ACP_REGS_VH

// Register addresses (8-bit address byte of a serial word)
`define ACP_ADDR_FMT_PWR 8'h63
`define ACP_ADDR_IFACE_RST 8'h6c
`define ACP_ADDR_REF_SEL 8'h6d

// Reset values of the three registers
`define ACP_FMT_PWR_RST 8'h00
`define ACP_IFACE_RST_RST 8'h00
`define ACP_REF_SEL_RST 8'h00

// Field positions in format_power_control
`define ACP_FMT_STANDBY_BIT 7
`define ACP_FMT_DF_BIT 3
`define ACP_FMT_LOWSPD_BIT 0

// Field positions in interface_and_soft_reset
`define ACP_IFACE_ODI_HI 4
`define ACP_IFACE_ODI_LO 3
`define ACP_IFACE_SWRST_BIT 1
`define ACP_ODI_CMOS 2'h3

// Field position in reference_select_control
`define ACP_REF_EXT_BIT 4

// Serial word layout
`define ACP_WORD_BITS 16
`define ACP_CNT_W 4
`define ACP_CNT_LAST 4'hf
`define ACP_CNT_ZERO 4'h0

// Two-bit level codes from the strap comparators
`define ACP_LVL_GND 2'h0
`define ACP_LVL_3_8 2'h1
`define ACP_LVL_5_8 2'h2
`define ACP_LVL_FULL 2'h3

// Output clock edge shifts, in 36ths of the sample period, signed
`define ACP_SHIFT_W 6
`define ACP_SHIFT_ZERO 6'h00
`define ACP_SHIFT_P3 6'h03
`define ACP_SHIFT_P5 6'h05
`define ACP_SHIFT_P6 6'h06
`define ACP_SHIFT_P7 6'h07
`define ACP_SHIFT_M3 6'h3d

// Timing
`define ACP_CLK_PERIOD_NS 100
`define ACP_RST_PULSE_MIN_NS 10
`define ACP_RST_PULSE_MAX_NS 1000
`define ACP_PAR_CNT_W 8

`endif

/* File: src/acp_ser_rx.v */
// Serial word receiver: synchronises the three port pins, assembles words
`timescale 1ns/1ns
`include "acp_regs.vh"

module acp_ser_rx (
  input wire i_clock,
  input wire i_rst_b,
  input wire i_ser_enable_n,
  input wire i_ser_clk,
  input wire i_ser_din,
  output reg o_word_valid,
  output reg [7:0] o_word_addr,
  output reg [7:0] o_word_data,
  output wire o_sen_level,
  output wire o_sclk_level,
  output wire o_din_level
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; first stage feeds only the second
  reg [2:0] meta_reg; // Stage one: {enable_n, clk, din}
  reg [2:0] sync_reg; // Stage two, safe to read
  reg sclk_prev_reg; // Last synced serial clock, for edge finding
  reg [14:0] shift_reg; // Bits gathered so far in this word
  reg [`ACP_CNT_W-1:0] cnt_reg; // Bit index within the current word
  wire sclk_fall;

  assign o_sen_level = sync_reg[2];
  assign o_sclk_level = sync_reg[1];
  assign o_din_level = sync_reg[0];
  // Clock and data pass the same two stages, so their skew is preserved
  assign sclk_fall = sclk_prev_reg & ~sync_reg[1];

  // Synchroniser chain
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= 3'h7;
      sync_reg <= 3'h7;
      sclk_prev_reg <= 1'b1; // Matches the parked-high clock, no false edge
    end else begin
      meta_reg <= {i_ser_enable_n, i_ser_clk, i_ser_din};
      sync_reg <= meta_reg;
      sclk_prev_reg <= sync_reg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shifter: address byte first, data byte second, MSB first
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_reg <= 15'h0000;
      cnt_reg <= `ACP_CNT_ZERO;
      o_word_valid <= 1'b0;
      o_word_addr <= 8'h00;
      o_word_data <= 8'h00;
    end else begin
      o_word_valid <= 1'b0;
      if (sync_reg[2]) begin
        // Enable high: partial word dropped, next window starts fresh
        cnt_reg <= `ACP_CNT_ZERO;
        shift_reg <= 15'h0000;
      end else if (sclk_fall) begin
        // Capture only on falling serial clock while enabled
        shift_reg <= {shift_reg[13:0], sync_reg[0]};
        cnt_reg <= cnt_reg + 1'b1;
        if (cnt_reg == `ACP_CNT_LAST) begin
          // Sixteenth edge commits; counter wraps for the next word
          o_word_valid <= 1'b1;
          o_word_addr <= shift_reg[14:7];
          o_word_data <= {shift_reg[6:0], sync_reg[0]};
        end
      end
    end
  end

endmodule // acp_ser_rx

/* File: src/acp_top.v */
// Converter configuration front end: strap decode, serial registers, priority
`timescale 1ns/1ns
`include "acp_regs.vh"

module acp_top #(
  parameter CLK_PERIOD_NS = `ACP_CLK_PERIOD_NS // Own clock period
) (
  input wire i_clock,
  input wire i_rst_b,
  input wire i_reset_pin,
  input wire i_ser_enable_n,
  input wire i_ser_clk,
  input wire i_ser_din,
  input wire [1:0] i_ser_enable_level,
  input wire [1:0] i_format_iface_strap,
  input wire [1:0] i_ref_strap,
  output reg o_parallel_mode,
  output reg o_data_format_bit,
  output reg o_cmos_output,
  output reg o_ext_reference,
  output reg o_low_speed,
  output reg o_standby,
  output reg [`ACP_SHIFT_W-1:0] o_clk_rise_shift,
  output reg [`ACP_SHIFT_W-1:0] o_clk_fall_shift
);

  ////////////////////////////////////////////////////////////////////////////
  // Timing: a reset pin held high past the longest pulse means parallel mode
  localparam integer PAR_CYC_RAW = `ACP_RST_PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam integer PAR_CYC = (PAR_CYC_RAW < 1) ? 1 : PAR_CYC_RAW;
  localparam [`ACP_PAR_CNT_W-1:0] PAR_CNT_MAX = PAR_CYC[`ACP_PAR_CNT_W-1:0];

  // Format strap decode: returns {offset_binary, cmos}
  function [1:0] dec_fmt;
    input [1:0] lvl;
    begin
      case (lvl)
        `ACP_LVL_GND: dec_fmt = 2'h0; // Two's comp, LVDS
        `ACP_LVL_3_8: dec_fmt = 2'h1; // Two's comp, CMOS
        `ACP_LVL_5_8: dec_fmt = 2'h3; // Offset binary, CMOS
        default: dec_fmt = 2'h2; // Offset binary, LVDS
      endcase
    end
  endfunction

  // Reference strap decode: 1 selects the external reference
  function dec_ref;
    input [1:0] lvl;
    begin
      dec_ref = (lvl == `ACP_LVL_3_8) || (lvl == `ACP_LVL_5_8);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin catcher: asynchronously set so a pulse far shorter than the
  // clock period still lands; cleared once the synchroniser has seen it
  reg catch_reg; // Sticky capture of a high reset pin
  reg catch_meta_reg; // First sync stage, read only by the next
  reg catch_sync_reg; // Reset pin seen high (or recently pulsed)
  wire catch_clr;

  assign catch_clr = catch_sync_reg;

  // Catcher, preset by the pin itself; cleared by the block reset so it
  // never powers up unknown and fakes a long high pin
  always @(posedge i_clock or posedge i_reset_pin or negedge i_rst_b) begin
    if (!i_rst_b) begin
      catch_reg <= 1'b0;
    end else if (i_reset_pin) begin
      catch_reg <= 1'b1;
    end else if (catch_clr) begin
      catch_reg <= 1'b0;
    end
  end

  // Catcher synchroniser
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      catch_meta_reg <= 1'b0;
      catch_sync_reg <= 1'b0;
    end else begin
      catch_meta_reg <= catch_reg;
      catch_sync_reg <= catch_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchronisers; levels are static so per-bit skew is harmless
  reg [5:0] strap_meta_reg; // First stage
  reg [5:0] strap_sync_reg; // {enable level, format, reference}
  wire [1:0] sen_lvl;
  wire [1:0] fmt_lvl;
  wire [1:0] ref_lvl;

  assign sen_lvl = strap_sync_reg[5:4];
  assign fmt_lvl = strap_sync_reg[3:2];
  assign ref_lvl = strap_sync_reg[1:0];

  // Strap sampling
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strap_meta_reg <= 6'h00;
      strap_sync_reg <= 6'h00;
    end else begin
      strap_meta_reg <= {i_ser_enable_level, i_format_iface_strap,
                         i_ref_strap};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial receiver. Pins are sampled at the own clock, so the fastest
  // usable serial clock is well below half of it; slow rates and any duty
  // cycle are fine since only edges are counted
  wire word_valid;
  wire [7:0] word_addr;
  wire [7:0] word_data;
  wire sclk_level;
  wire din_level;

  acp_ser_rx u_rx (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_ser_enable_n(i_ser_enable_n),
    .i_ser_clk(i_ser_clk),
    .i_ser_din(i_ser_din),
    .o_word_valid(word_valid),
    .o_word_addr(word_addr),
    .o_word_data(word_data),
    .o_sen_level(),
    .o_sclk_level(sclk_level),
    .o_din_level(din_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode detect: count cycles of a continuously high reset pin
  reg [`ACP_PAR_CNT_W-1:0] par_cnt_reg; // High-time counter
  reg par_mode_reg; // Parallel control mode in force

  // Parallel mode after the pin has been high longer than any pulse
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      par_cnt_reg <= {`ACP_PAR_CNT_W{1'b0}};
      par_mode_reg <= 1'b0;
    end else if (!catch_sync_reg) begin
      par_cnt_reg <= {`ACP_PAR_CNT_W{1'b0}};
      par_mode_reg <= 1'b0;
    end else if (par_cnt_reg == PAR_CNT_MAX) begin
      par_mode_reg <= 1'b1;
    end else begin
      par_cnt_reg <= par_cnt_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, write only over the serial port
  reg [7:0] fmt_pwr_reg; // format_power_control
  reg [7:0] iface_reg; // interface_and_soft_reset
  reg [7:0] ref_reg; // reference_select_control
  wire soft_rst;
  wire wr_ok;

  // Writes are ignored while the reset pin is high
  assign wr_ok = word_valid & ~catch_sync_reg;
  assign soft_rst = wr_ok && (word_addr == `ACP_ADDR_IFACE_RST) &&
                    word_data[`ACP_IFACE_SWRST_BIT];

  // Register file with hardware and soft reset to defaults
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fmt_pwr_reg <= `ACP_FMT_PWR_RST;
      iface_reg <= `ACP_IFACE_RST_RST;
      ref_reg <= `ACP_REF_SEL_RST;
    end else if (catch_sync_reg || soft_rst) begin
      // Pin pulse or soft bit: all defaults, soft bit stored as zero
      fmt_pwr_reg <= `ACP_FMT_PWR_RST;
      iface_reg <= `ACP_IFACE_RST_RST;
      ref_reg <= `ACP_REF_SEL_RST;
    end else if (wr_ok) begin
      case (word_addr)
        `ACP_ADDR_FMT_PWR: begin
          fmt_pwr_reg <= word_data;
        end
        `ACP_ADDR_IFACE_RST: begin
          iface_reg <= word_data;
        end
        `ACP_ADDR_REF_SEL: begin
          ref_reg <= word_data;
        end
        default: begin
          // Unmapped addresses are dropped
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode resolution between straps and registers
  reg nx_df;
  reg nx_cmos;
  reg nx_ref;
  reg nx_lowspd;
  reg nx_stby;
  reg [`ACP_SHIFT_W-1:0] nx_rise;
  reg [`ACP_SHIFT_W-1:0] nx_fall;
  reg [1:0] strap_fmt;

  // Priority and parallel decode
  always @* begin
    strap_fmt = dec_fmt(fmt_lvl);
    nx_rise = `ACP_SHIFT_ZERO;
    nx_fall = `ACP_SHIFT_ZERO;
    if (par_mode_reg) begin
      nx_df = strap_fmt[1];
      nx_cmos = strap_fmt[0];
      nx_ref = dec_ref(ref_lvl);
      nx_lowspd = sclk_level;
      nx_stby = din_level;
      if (strap_fmt[0]) begin
        // CMOS output edge placement
        case (sen_lvl)
          `ACP_LVL_GND: begin
            nx_rise = `ACP_SHIFT_P3;
            nx_fall = `ACP_SHIFT_P3;
          end
          `ACP_LVL_3_8: begin
            nx_rise = `ACP_SHIFT_P5;
            nx_fall = `ACP_SHIFT_P5;
          end
          `ACP_LVL_5_8: begin
            nx_rise = `ACP_SHIFT_M3;
            nx_fall = `ACP_SHIFT_M3;
          end
          default: begin
            nx_rise = `ACP_SHIFT_ZERO;
          end
        endcase
      end else begin
        // LVDS output edge placement
        case (sen_lvl)
          `ACP_LVL_GND, `ACP_LVL_3_8: begin
            nx_rise = `ACP_SHIFT_P7;
            nx_fall = `ACP_SHIFT_P6;
          end
          `ACP_LVL_5_8: begin
            nx_rise = `ACP_SHIFT_P3;
            nx_fall = `ACP_SHIFT_P3;
          end
          default: begin
            nx_rise = `ACP_SHIFT_ZERO;
          end
        endcase
      end
    end else begin
      // Serial or combined mode; straps stay live where allowed
      nx_df = (fmt_lvl == `ACP_LVL_GND) ?
              fmt_pwr_reg[`ACP_FMT_DF_BIT] : strap_fmt[1];
      nx_cmos = (iface_reg[`ACP_IFACE_ODI_HI:`ACP_IFACE_ODI_LO] ==
                 `ACP_ODI_CMOS);
      nx_ref = (ref_lvl == `ACP_LVL_GND) ?
               ref_reg[`ACP_REF_EXT_BIT] : dec_ref(ref_lvl);
      nx_lowspd = fmt_pwr_reg[`ACP_FMT_LOWSPD_BIT];
      nx_stby = fmt_pwr_reg[`ACP_FMT_STANDBY_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_parallel_mode <= 1'b0;
      o_data_format_bit <= 1'b0;
      o_cmos_output <= 1'b0;
      o_ext_reference <= 1'b0;
      o_low_speed <= 1'b0;
      o_standby <= 1'b0;
      o_clk_rise_shift <= `ACP_SHIFT_ZERO;
      o_clk_fall_shift <= `ACP_SHIFT_ZERO;
    end else begin
      o_parallel_mode <= par_mode_reg;
      o_data_format_bit <= nx_df;
      o_cmos_output <= nx_cmos;
      o_ext_reference <= nx_ref;
      o_low_speed <= nx_lowspd;
      o_standby <= nx_stby;
      o_clk_rise_shift <= nx_rise;
      o_clk_fall_shift <= nx_fall;
    end
  end

endmodule // acp_top

/* File: tb/acp_checker.sv */
// Port-level assertions for the converter configuration front end
`timescale 1ns/1ns
`include "acp_regs.vh"

module acp_checker #(
  parameter CLK_PERIOD_NS = `ACP_CLK_PERIOD_NS // Own clock period
) (
  input wire i_clock,
  input wire i_rst_b,
  input wire i_reset_pin,
  input wire i_ser_enable_n,
  input wire i_ser_clk,
  input wire i_ser_din,
  input wire [1:0] i_ser_enable_level,
  input wire [1:0] i_format_iface_strap,
  input wire [1:0] i_ref_strap,
  input wire o_parallel_mode,
  input wire o_data_format_bit,
  input wire o_cmos_output,
  input wire o_ext_reference,
  input wire o_low_speed,
  input wire o_standby,
  input wire [`ACP_SHIFT_W-1:0] o_clk_rise_shift,
  input wire [`ACP_SHIFT_W-1:0] o_clk_fall_shift
);
  // Margin above the parallel threshold covers sync and output stages
  localparam int PAR_LIM = `ACP_RST_PULSE_MAX_NS / CLK_PERIOD_NS + 6;
  logic [4:0] hi_cnt_reg; // Cycles with reset pin high, saturating

  ////////////////////////////////////////////////////////////////////////
  // Count how long the reset pin has stood high
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) hi_cnt_reg <= 5'h00;
    else if (!i_reset_pin) hi_cnt_reg <= 5'h00;
    else if (hi_cnt_reg != 5'h1f) hi_cnt_reg <= hi_cnt_reg + 5'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  AST_PAR_ENTRY: assert property (
    hi_cnt_reg >= PAR_LIM |-> o_parallel_mode)
    else $error("parallel mode missing after long reset pin");
  AST_SER_EXIT: assert property (
    (!i_reset_pin) [*6] |-> !o_parallel_mode)
    else $error("parallel mode kept with reset pin low");
  AST_HW_RESET: assert property (
    $rose(i_reset_pin) && !o_parallel_mode
    |-> ##5 !o_standby && !o_low_speed && !o_cmos_output)
    else $error("registers not at defaults after reset pin");
  AST_LOW_SPEED: assert property (
    (o_parallel_mode && $stable(i_ser_clk)) [*6]
    |-> o_low_speed == i_ser_clk) else $error("low speed not from clock pin");
  AST_STANDBY: assert property (
    (o_parallel_mode && $stable(i_ser_din)) [*6]
    |-> o_standby == i_ser_din) else $error("standby not from data pin");
  AST_FMT_STRAP: assert property (($stable(i_format_iface_strap)
    && i_format_iface_strap != 2'h0) [*6]
    |-> o_data_format_bit == i_format_iface_strap[1])
    else $error("format not decided by strap");
  AST_REF_STRAP: assert property (
    ($stable(i_ref_strap) && i_ref_strap != 2'h0) [*6]
    |-> o_ext_reference == (i_ref_strap[1] ^ i_ref_strap[0]))
    else $error("reference not decided by strap");
  AST_PAR_CMOS: assert property ((o_parallel_mode
    && $stable(i_format_iface_strap)) [*6]
    |-> o_cmos_output == (i_format_iface_strap[1] ^ i_format_iface_strap[0]))
    else $error("interface not decoded from strap");
  AST_EDGE_DEFAULT: assert property ((o_parallel_mode
    && i_ser_enable_level == 2'h3) [*6]
    |-> o_clk_rise_shift == 6'h00 && o_clk_fall_shift == 6'h00)
    else $error("edge shift not default at full level");
  AST_LVDS_SHIFT: assert property (
    (o_parallel_mode && i_ser_enable_level == 2'h0
    && i_format_iface_strap == 2'h0) [*6] |-> o_clk_rise_shift == 6'h07
    && o_clk_fall_shift == 6'h06) else $error("lvds edge shift wrong");

  // Main scenarios reached
  cover property (o_parallel_mode && o_cmos_output);
  cover property ($rose(o_standby) && !o_parallel_mode);
  cover property ($fell(o_parallel_mode));
endmodule // acp_checker

bind acp_top acp_checker #(.CLK_PERIOD_NS(CLK_PERIOD_NS)) u_checker (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_reset_pin(i_reset_pin),
  .i_ser_enable_n(i_ser_enable_n), .i_ser_clk(i_ser_clk),
  .i_ser_din(i_ser_din), .i_ser_enable_level(i_ser_enable_level),
  .i_format_iface_strap(i_format_iface_strap), .i_ref_strap(i_ref_strap),
  .o_parallel_mode(o_parallel_mode), .o_data_format_bit(o_data_format_bit),
  .o_cmos_output(o_cmos_output), .o_ext_reference(o_ext_reference),
  .o_low_speed(o_low_speed), .o_standby(o_standby),
  .o_clk_rise_shift(o_clk_rise_shift), .o_clk_fall_shift(o_clk_fall_shift));

/* File: tb/acp_host_model.sv */
// Host controller model driving the three-wire serial port
`timescale 1ns/1ns

module acp_host_model (
  input wire i_clock, // All changes land on its rising edge
  output logic o_ser_enable_n, // Serial enable, active low
  output logic o_ser_clk, // Serial clock, left high after each frame; park sets its level
  output logic o_ser_din // Serial data
);
  // Idle lines at time zero
  initial begin
    o_ser_enable_n = 1'b1;
    o_ser_clk = 1'b1;
    o_ser_din = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // One enable window of n bits, MSB first, 800 ns per serial clock
  task automatic send(input logic [63:0] bits, input int n);
    int i;
    @(posedge i_clock);
    o_ser_enable_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    for (i = n - 1; i >= 0; i--) begin
      o_ser_din <= bits[i];
      o_ser_clk <= 1'b1;
      repeat (4) @(posedge i_clock);
      o_ser_clk <= 1'b0;
      repeat (2) @(posedge i_clock);
      o_ser_din <= ~bits[i]; // Hold over: stale value must not be trusted
      repeat (2) @(posedge i_clock);
    end
    o_ser_clk <= 1'b1;
    repeat (2) @(posedge i_clock);
    o_ser_enable_n <= 1'b1;
  endtask

  // Static levels for parallel control
  task automatic park(input logic sc, input logic d);
    @(posedge i_clock);
    o_ser_clk <= sc;
    o_ser_din <= d;
  endtask
endmodule // acp_host_model

/* File: tb/tb_adc_config_port.sv */
// Self-checking testbench for the converter configuration front end
`timescale 1ns/1ns
`include "acp_regs.vh"

module tb_adc_config_port;
  logic i_clock = 1'b0; // 10 MHz system clock
  logic i_rst_b = 1'b0; // Async reset, active low
  logic i_reset_pin = 1'b0; // Device reset pin
  logic [1:0] i_ser_enable_level = 2'h3; // Enable pin level code
  logic [1:0] i_format_iface_strap = 2'h0; // Grounded for serial use
  logic [1:0] i_ref_strap = 2'h0; // Grounded for serial use
  wire ser_enable_n, ser_clk, ser_din; // Host serial lines
  wire o_parallel_mode, o_data_format_bit, o_cmos_output;
  wire o_ext_reference, o_low_speed, o_standby;
  wire [`ACP_SHIFT_W-1:0] o_clk_rise_shift, o_clk_fall_shift;
  wire [17:0] seen = {o_parallel_mode, o_data_format_bit, o_cmos_output,
    o_ext_reference, o_low_speed, o_standby, o_clk_rise_shift,
    o_clk_fall_shift}; // All outputs packed
  logic [17:0] exp_q[$]; // Expected output notes, oldest first
  event look; // Outputs settled, compare now
  int bad_count = 0;
  int comparisons = 0;
  integer seed = 32'h1951; // Fixed seed
  int i;
  logic sc, d; // Parallel clock and data pin levels
  logic [1:0] r; // Random reference strap
  logic [31:0] rnd; // Raw random word, cut to the pin levels below

  always #50 i_clock = ~i_clock;

  acp_host_model u_host (.i_clock(i_clock), .o_ser_enable_n(ser_enable_n),
    .o_ser_clk(ser_clk), .o_ser_din(ser_din));

  acp_top u_dut (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_reset_pin(i_reset_pin), .i_ser_enable_n(ser_enable_n),
    .i_ser_clk(ser_clk), .i_ser_din(ser_din),
    .i_ser_enable_level(i_ser_enable_level),
    .i_format_iface_strap(i_format_iface_strap), .i_ref_strap(i_ref_strap),
    .o_parallel_mode(o_parallel_mode), .o_data_format_bit(o_data_format_bit),
    .o_cmos_output(o_cmos_output), .o_ext_reference(o_ext_reference),
    .o_low_speed(o_low_speed), .o_standby(o_standby),
    .o_clk_rise_shift(o_clk_rise_shift), .o_clk_fall_shift(o_clk_fall_shift));

  ////////////////////////////////////////////////////////////////////////
  // Expected outputs in serial mode: shifts are zero there
  function automatic logic [17:0] ser(input logic f, c, e, lo, sb);
    return {1'b0, f, c, e, lo, sb, 12'h000};
  endfunction

  // Expected outputs in parallel mode from strap codes and pin levels
  function automatic logic [17:0] par(input logic [1:0] s, rf, l,
    input logic sck, dn);
    logic c;
    logic [5:0] ri, fa;
    c = s[0] ^ s[1];
    case ({c, l})
      3'h0, 3'h1: {ri, fa} = {`ACP_SHIFT_P7, `ACP_SHIFT_P6};
      3'h2, 3'h4: {ri, fa} = {`ACP_SHIFT_P3, `ACP_SHIFT_P3};
      3'h5: {ri, fa} = {`ACP_SHIFT_P5, `ACP_SHIFT_P5};
      3'h6: {ri, fa} = {`ACP_SHIFT_M3, `ACP_SHIFT_M3};
      default: {ri, fa} = {`ACP_SHIFT_ZERO, `ACP_SHIFT_ZERO};
    endcase
    return {1'b1, s[1], c, rf[0] ^ rf[1], sck, dn, ri, fa};
  endfunction

  task check(input logic [17:0] seen_v, input logic [17:0] exp_v);
    comparisons++;
    if (seen_v !== exp_v) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask

  // Let outputs settle, then note the expectation for the watcher
  task note_exp(input logic [17:0] v);
    repeat (8) @(posedge i_clock);
    #10;
    exp_q.push_back(v);
    -> look;
  endtask

  task straps(input logic [1:0] f, rf, l);
    @(posedge i_clock);
    i_format_iface_strap <= f;
    i_ref_strap <= rf;
    i_ser_enable_level <= l;
  endtask

  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watcher: oldest note against the outputs
  always @(look) check(seen, exp_q.pop_front());

  // Hang guard, well beyond the expected run of about 1330 cycles
  initial begin
    #2_000_000;
    bad_count++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clock);
    i_reset_pin <= 1'b1; // One-cycle pulse, wider than 10 ns
    @(posedge i_clock);
    i_reset_pin <= 1'b0;
    note_exp(ser(0, 0, 0, 0, 0));
    u_host.send({8'h63, 8'h89}, 16);
    note_exp(ser(1, 0, 0, 1, 1));
    // Back-to-back words, an unmapped address, then five loose bits
    u_host.send({8'h6c, 8'h18, 8'h6d, 8'h10, 8'h64, 8'hff, 5'h00}, 53);
    note_exp(ser(1, 1, 1, 1, 1));
    // A partial window must not shift the next one out of step
    u_host.send(9'h1ff, 9);
    u_host.send({8'h63, 8'h01}, 16);
    note_exp(ser(0, 1, 1, 1, 0));
    // Straps in every level: nonzero codes override register bits
    for (i = 0; i < 4; i++) begin
      straps(i[1:0], i[1:0], 2'h3);
      note_exp(ser(i[1], 1'b1, i != 3, 1'b1, 1'b0));
    end
    straps(2'h0, 2'h0, 2'h3);
    // Soft reset with other bits set, then a write proves self-clear
    u_host.send({8'h6c, 8'h1a}, 16);
    note_exp(ser(0, 0, 0, 0, 0));
    u_host.send({8'h63, 8'h80}, 16);
    note_exp(ser(0, 0, 0, 0, 1));
    // Parallel control: every enable level with every format strap
    @(posedge i_clock);
    i_reset_pin <= 1'b1;
    repeat (20) @(posedge i_clock);
    for (i = 0; i < 16; i++) begin
      rnd = $random(seed);
      sc = rnd[0];
      d = rnd[1];
      r = rnd[3:2];
      u_host.park(sc, d);
      straps(i[3:2], r, i[1:0]);
      note_exp(par(i[3:2], r, i[1:0], sc, d));
    end
    // Back to serial: registers still at defaults
    u_host.park(1'b1, 1'b1);
    straps(2'h0, 2'h0, 2'h3);
    @(posedge i_clock);
    i_reset_pin <= 1'b0;
    note_exp(ser(0, 0, 0, 0, 0));
    // Let the watcher take the last note before the verdict
    @(posedge i_clock);
    if (exp_q.size() != 0) bad_count++;
    tally_and_finish;
  end
endmodule // tb_adc_config_port
